/* File: shared/sub_table_pkg.sv */
// constants for the subtract and table-read execution unit
// assumes a core that presents one decoded operation per cycle
package sub_table_pkg;
   localparam int DATA_W = 8;
   localparam int FILE_ADDR_W = 6;
   localparam int SPEC_IDX_W = 4;
   localparam int ROM_W = 14;
   localparam int PTR_W = 3;
   localparam int ROM_ADDR_W = 11;
   localparam int HI_DATA_W = 6;
   localparam int HI_LSB = 8;
   localparam int HI_MSB = 13;
   localparam int NIB_W = 4;
   localparam logic [7:0] WORK_RST = 8'h00;
   localparam logic [5:0] HI_DATA_RST = 6'h00;
   localparam logic [2:0] PTR_RST = 3'h0;
   // operation codes from the decoder
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_MOVE_SPECIAL = 3'h1,
      OP_SUB_FILE = 3'h2,
      OP_SUB_IMM = 3'h3,
      OP_TABLE_READ = 3'h4
   } op_t;
endpackage : sub_table_pkg

/* File: rtl/sub_table_exec.sv */
// execution unit for special move, two subtracts and program word read
// assumes decoder issues op_start_i one cycle, holds off while busy_o
//
// Overview of operation
// RULE1 - special register copied to work, flags kept
// RULE2 - file minus work, one cycle, flags updated
// RULE3 - destination bit picks work or file
// RULE4 - immediate minus work into work register
// RULE5 - address is pointer low bits over work
// RULE6 - upper bits to high data, two cycles
// RULE7 - program words fourteen bits, top six upper
// RULE8 - carry means no borrow, zero on zero
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module sub_table_exec
   import sub_table_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic nrst_i,
   // decoded operation
   input wire logic op_start_i,
   input wire sub_table_pkg::op_t op_i,
   input wire logic [sub_table_pkg::FILE_ADDR_W-1:0] file_addr_i,
   input wire logic dest_file_i,
   input wire logic [sub_table_pkg::SPEC_IDX_W-1:0] spec_idx_i,
   input wire logic [sub_table_pkg::DATA_W-1:0] imm_i,
   // register file and special page read data
   input wire logic [sub_table_pkg::DATA_W-1:0] file_rdata_i,
   input wire logic [sub_table_pkg::DATA_W-1:0] spec_rdata_i,
   input wire logic [sub_table_pkg::PTR_W-1:0] table_high_pointer_i,
   // register file write and special page select
   output logic [sub_table_pkg::FILE_ADDR_W-1:0] file_addr_o,
   output logic [sub_table_pkg::SPEC_IDX_W-1:0] spec_idx_o,
   output logic file_we_o,
   output logic [sub_table_pkg::DATA_W-1:0] file_wdata_o,
   // program memory
   output logic [sub_table_pkg::ROM_ADDR_W-1:0] rom_addr_o,
   output logic rom_re_o,
   input wire logic [sub_table_pkg::ROM_W-1:0] rom_data_i,
   // architectural state
   output logic [sub_table_pkg::DATA_W-1:0] work_register_o,
   output logic [sub_table_pkg::HI_DATA_W-1:0] table_high_data_o,
   output logic zero_flag_o,
   output logic digit_carry_flag_o,
   output logic carry_flag_o,
   output logic busy_o
);
   import sub_table_pkg::*;

   // reset release through two flops
   logic rst_s1_r, rst_n_r;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // one-hot states: idle, or waiting on the program word
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_TABLE = 2'b10
   } state_t;

   // a minus b with no-borrow flags
   function automatic logic [10:0] sub8(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, a} + {1'b0, ~b} + 9'h001;
      low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      sub8 = {full[8], low[4], (full[7:0] == 8'h00), full[7:0]};
   endfunction : sub8

   // execution registers and their next values
   state_t state_r, state_nxt;
   logic [7:0] work_r, work_nxt;
   logic [5:0] hi_r, hi_nxt;
   logic z_r, z_nxt, dc_r, dc_nxt, c_r, c_nxt;
   logic [10:0] diff;
   logic go;

   // handshake and pass-through outputs
   assign go = op_start_i && (state_r == ST_IDLE);
   assign file_addr_o = file_addr_i;
   assign spec_idx_o = spec_idx_i;
   assign rom_addr_o = {table_high_pointer_i, work_r}; // RULE5
   assign rom_re_o = go && (op_i == OP_TABLE_READ);
   assign busy_o = (state_r == ST_TABLE);

   // architectural state straight from the registers
   assign work_register_o = work_r;
   assign table_high_data_o = hi_r;
   assign zero_flag_o = z_r;
   assign digit_carry_flag_o = dc_r;
   assign carry_flag_o = c_r;

   // next state of the execution registers
   always_comb begin
      state_nxt = state_r;
      work_nxt = work_r;
      hi_nxt = hi_r;
      z_nxt = z_r;
      dc_nxt = dc_r;
      c_nxt = c_r;
      file_we_o = 1'b0;
      file_wdata_o = 8'h00;
      diff = sub8((op_i == OP_SUB_IMM) ? imm_i : file_rdata_i, work_r); // RULE2 RULE4
      case (state_r)
         ST_IDLE: begin
            if (op_start_i) begin
               case (op_i)
                  OP_MOVE_SPECIAL: work_nxt = spec_rdata_i; // RULE1
                  OP_SUB_FILE, OP_SUB_IMM: begin
                     c_nxt = diff[10]; // RULE8
                     dc_nxt = diff[9];
                     z_nxt = diff[8]; // RULE8
                     if (op_i == OP_SUB_FILE && dest_file_i) begin
                        file_we_o = 1'b1; // RULE3
                        file_wdata_o = diff[7:0];
                     end else begin
                        work_nxt = diff[7:0]; // RULE3 RULE4
                     end
                  end
                  OP_TABLE_READ: state_nxt = ST_TABLE; // RULE6
                  default: ;
               endcase
            end
         end
         ST_TABLE: begin
            // memory answers in the second cycle
            work_nxt = rom_data_i[HI_LSB-1:0]; // RULE5
            hi_nxt = rom_data_i[HI_MSB:HI_LSB]; // RULE6 RULE7
            state_nxt = ST_IDLE;
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   // register the execution state
   always_ff @(posedge clock_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         state_r <= ST_IDLE;
         work_r <= WORK_RST;
         hi_r <= HI_DATA_RST;
         z_r <= 1'b0;
         dc_r <= 1'b0;
         c_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         work_r <= work_nxt;
         hi_r <= hi_nxt;
         z_r <= z_nxt;
         dc_r <= dc_nxt;
         c_r <= c_nxt;
      end
   end

   // special move: work register loaded, nothing else touched
   a_move_flags_kept: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE1
      go && op_i == OP_MOVE_SPECIAL |=> work_r == $past(spec_rdata_i)
         && $stable(c_r) && $stable(z_r) && $stable(dc_r))
      else $error("special move wrong");
   a_move_no_write: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE1
      go && op_i == OP_MOVE_SPECIAL |-> !file_we_o && !rom_re_o)
      else $error("special move wrote elsewhere");

   // file subtract: destination bit picks work or file
   a_sub_file_dest: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE3
      go && op_i == OP_SUB_FILE && dest_file_i |-> file_we_o ##1 $stable(work_r))
      else $error("file destination wrong");
   a_sub_file_value: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE2
      go && op_i == OP_SUB_FILE && !dest_file_i
         |=> work_r == 8'($past(file_rdata_i) - $past(work_r)))
      else $error("file subtract wrong");
   a_file_wdata: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE3
      go && op_i == OP_SUB_FILE && dest_file_i
         |-> file_wdata_o == 8'(file_rdata_i - work_r))
      else $error("file write data wrong");
   a_we_only_file: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE3
      file_we_o |-> go && op_i == OP_SUB_FILE && dest_file_i)
      else $error("stray file write");

   // immediate subtract into the work register
   a_sub_imm_value: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE4
      go && op_i == OP_SUB_IMM |=> work_r == 8'($past(imm_i) - $past(work_r)))
      else $error("immediate subtract wrong");

   // flags of both subtracts: carry and digit carry mean no borrow
   a_carry_borrow: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE8
      go && op_i == OP_SUB_IMM |=> c_r == ($past(imm_i) >= $past(work_r)))
      else $error("carry wrong");
   a_zero_flag: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE8
      go && op_i == OP_SUB_IMM |=> z_r == ($past(imm_i) == $past(work_r)))
      else $error("zero wrong");
   a_file_carry: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE8
      go && op_i == OP_SUB_FILE |=> c_r == ($past(file_rdata_i) >= $past(work_r)))
      else $error("file carry wrong");
   a_file_zero: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE8
      go && op_i == OP_SUB_FILE |=> z_r == ($past(file_rdata_i) == $past(work_r)))
      else $error("file zero wrong");
   a_imm_digit: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE4
      go && op_i == OP_SUB_IMM |=> dc_r == (4'($past(imm_i)) >= 4'($past(work_r))))
      else $error("immediate digit carry wrong");
   a_file_digit: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE2
      go && op_i == OP_SUB_FILE |=> dc_r == (4'($past(file_rdata_i)) >= 4'($past(work_r))))
      else $error("file digit carry wrong");

   // program word read: address, two cycles, requests refused while busy
   a_table_addr: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE5
      rom_re_o |-> rom_addr_o == {table_high_pointer_i, work_r})
      else $error("table address wrong");
   a_table_two_cyc: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE6 RULE7
      rom_re_o |=> busy_o ##1 !busy_o && hi_r == 6'($past(rom_data_i) >> HI_LSB)
         && work_r == 8'($past(rom_data_i)))
      else $error("table read wrong");
   a_busy_refuses: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE6
      busy_o |-> !rom_re_o && !file_we_o)
      else $error("request taken while busy");
   a_busy_flags_kept: assert property (@(posedge clock_i) disable iff (!rst_n_r) // RULE6
      busy_o |=> $stable(z_r) && $stable(c_r) && $stable(dc_r))
      else $error("table read touched flags");
endmodule : sub_table_exec
`default_nettype wire

/* File: verification/tb.sv */
// bench for sub_table_exec: move, subtracts, program word read
// assumes sub_table_pkg compiled first; one 50 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sub_table_pkg::*;
   logic clock_i, nrst_i, op_start_i, dest_file_i, file_we_o, rom_re_o, busy_o;
   logic zero_flag_o, digit_carry_flag_o, carry_flag_o;
   op_t op_i;
   logic [5:0] file_addr_i, file_addr_o, table_high_data_o;
   logic [3:0] spec_idx_i, spec_idx_o;
   logic [7:0] imm_i, file_rdata_i, spec_rdata_i, file_wdata_o, work_register_o;
   logic [2:0] table_high_pointer_i;
   logic [10:0] rom_addr_o;
   logic [13:0] rom_data_i;
   int n_mismatch = 0, cmp_count = 0, cyc = 0;
   sub_table_exec dut (.clock_i, .nrst_i, .op_start_i, .op_i, .file_addr_i, .dest_file_i,
      .spec_idx_i, .imm_i, .file_rdata_i, .spec_rdata_i, .table_high_pointer_i, .file_addr_o,
      .spec_idx_o, .file_we_o, .file_wdata_o, .rom_addr_o, .rom_re_o, .rom_data_i,
      .work_register_o, .table_high_data_o, .zero_flag_o, .digit_carry_flag_o,
      .carry_flag_o, .busy_o);
   // clock generation
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   // compare and count
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // start one operation, operand v on the immediate, file and special read data inputs
   task issue(input op_t o, input logic [7:0] v, input logic d);
      @(posedge clock_i);
      op_start_i <= 1'b1;
      op_i <= o;
      imm_i <= v;
      file_rdata_i <= v;
      spec_rdata_i <= v;
      dest_file_i <= d;
      #1;
   endtask : issue
   task done_op;
      @(posedge clock_i);
      op_start_i <= 1'b0;
      spec_rdata_i <= 8'ha5;
      #1;
   endtask : done_op
   task t_move_keeps_flags;
      issue(OP_MOVE_SPECIAL, 8'h05, 1'b0);
      done_op();
      issue(OP_SUB_IMM, 8'h05, 1'b0);
      done_op();
      chk("zero sub", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h7);
      issue(OP_MOVE_SPECIAL, 8'h06, 1'b0);
      chk("spec idx", spec_idx_o, 4'hf);
      done_op();
      chk("work move", work_register_o, 8'h06);
      chk("flags kept", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h7);
   endtask : t_move_keeps_flags
   task t_sub_imm_borrow;
      issue(OP_SUB_IMM, 8'h05, 1'b0);
      done_op();
      chk("work imm", work_register_o, 8'hff);
      chk("flags imm", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h0);
   endtask : t_sub_imm_borrow
   task t_sub_file;
      issue(OP_MOVE_SPECIAL, 8'h05, 1'b0);
      done_op();
      issue(OP_SUB_FILE, 8'h06, 1'b1);
      chk("we d1", {file_we_o, file_addr_o, file_wdata_o}, {1'b1, 6'h3f, 8'h01});
      done_op();
      chk("work d1", work_register_o, 8'h05);
      chk("flags d1", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h3);
      issue(OP_SUB_FILE, 8'h05, 1'b0);
      chk("we d0", file_we_o, 1'b0);
      done_op();
      chk("work d0", work_register_o, 8'h00);
      chk("flags d0", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h7);
   endtask : t_sub_file
   task t_table_read;
      issue(OP_MOVE_SPECIAL, 8'h34, 1'b0);
      done_op();
      issue(OP_TABLE_READ, 8'h00, 1'b0);
      chk("rom addr", {rom_re_o, rom_addr_o}, {1'b1, 11'h234});
      // a request during busy must be ignored
      @(posedge clock_i);
      op_i <= OP_SUB_IMM;
      rom_data_i <= 14'h35aa;
      #1;
      chk("busy", busy_o, 1'b1);
      done_op();
      rom_data_i <= 14'h0a55;
      chk("work rom", work_register_o, 8'haa);
      chk("high data", table_high_data_o, 6'h35);
      chk("busy end", busy_o, 1'b0);
      chk("flags table", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h7);
   endtask : t_table_read
   // an empty operation code changes nothing
   task t_none_ignored;
      issue(OP_NONE, 8'h77, 1'b1);
      chk("none we", {file_we_o, rom_re_o}, 2'h0);
      done_op();
      chk("none work", work_register_o, 8'haa);
      chk("none high", table_high_data_o, 6'h35);
      chk("none flags", {zero_flag_o, digit_carry_flag_o, carry_flag_o}, 3'h7);
   endtask : t_none_ignored
   task stop_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   // hang guard
   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 2000) begin
         n_mismatch++;
         stop_test();
      end
   end
   // main sequence
   initial begin
      nrst_i = 1'b0;
      op_start_i = 1'b0;
      op_i = OP_NONE;
      dest_file_i = 1'b0;
      file_addr_i = 6'h3f;
      spec_idx_i = 4'hf;
      imm_i = 8'h00;
      file_rdata_i = 8'h00;
      spec_rdata_i = 8'h00;
      table_high_pointer_i = 3'h2;
      rom_data_i = 14'h0a55;
      repeat (10) @(posedge clock_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      t_move_keeps_flags();
      t_sub_imm_borrow();
      t_sub_file();
      t_table_read();
      t_none_ignored();
      // let pending checks finish
      repeat (2) @(posedge clock_i);
      stop_test();
   end
endmodule : tb
`default_nettype wire
